// >>> shared/skip_sub_pkg.sv
// How it works
// - inc_skip_nil increments memory, skips on zero.
// - Skip costs two cycles, dummy fills slot.
// - inc_to_acc_skip loads accumulator, memory untouched.
// - bit_set_skip skips when selected bit set.
// - minus_mem_op puts accumulator minus memory in accumulator.
// - Borrow flag cleared on negative, else set.
// - Subtracts update four flags; skips none.
// - minus_to_mem_op writes difference into memory.
// - Immediate subtract uses instruction constant.
package skip_sub_pkg;

   typedef enum logic [2:0] {
      OP_INC_SKIP_NIL = 3'b000,
      OP_INC_TO_ACC_SKIP = 3'b001,
      OP_BIT_SET_SKIP = 3'b010,
      OP_MINUS_MEM = 3'b011,
      OP_MINUS_TO_MEM = 3'b100,
      OP_MINUS_IMM = 3'b101
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_EXEC = 2'b10,
      ST_DUMMY = 2'b11
   } exec_state_e;

   localparam logic [11:0] OFS_CMD = 12'h000;
   localparam logic [11:0] OFS_ACC = 12'h004;
   localparam logic [11:0] OFS_FLAGS = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00c;
   localparam logic [3:0] RAM_WIN_HI = 4'h1;
   localparam int RAM_WIN_WORDS = 64;

   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BIT_LSB = 4;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_IMM_LSB = 16;

   localparam int FLAG_BORROW = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_NIL = 2;
   localparam int FLAG_WRAP = 3;

   localparam int STAT_BUSY = 0;
   localparam int STAT_SKIP = 1;
   localparam int STAT_BAD_OP = 2;
   localparam int STAT_CYC_LSB = 4;

   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int RAM_DEPTH_DEF = 64;
   localparam int CYC_DIV_DEF = 4;

endpackage

// >>> hw/exec_byte_ram.sv
`timescale 1ns/100ps
`default_nettype none
module exec_byte_ram #(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic [AW-1:0] addr,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_size
      $error("DEPTH does not fit the address width.");
   end

   // No reset on the array, so software must write a byte before trusting it.
   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[addr] <= wdata;
      end
      rdata <= mem_q[addr];
   end

endmodule
`default_nettype wire

// >>> hw/skip_sub_alu.sv
`timescale 1ns/100ps
`default_nettype none
module skip_sub_alu
   import skip_sub_pkg::*;
(
   input wire op_e op,
   input wire logic [7:0] acc,
   input wire logic [7:0] mem,
   input wire logic [7:0] imm,
   input wire logic [2:0] bit_sel,
   output logic [7:0] result,
   output logic [3:0] flags,
   output logic skip,
   output logic wr_acc,
   output logic wr_mem,
   output logic wr_flags,
   output logic bad_op
);

   function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
      sub9 = {1'b0, a} - {1'b0, b};
   endfunction

   wire logic is_imm = (op == OP_MINUS_IMM);
   wire logic is_sub = (op == OP_MINUS_MEM) || (op == OP_MINUS_TO_MEM) || is_imm;
   wire logic is_inc = (op == OP_INC_SKIP_NIL) || (op == OP_INC_TO_ACC_SKIP);
   wire logic [7:0] subtrahend = is_imm ? imm : mem;
   wire logic [8:0] diff = sub9(acc, subtrahend);
   wire logic [8:0] nib_diff = sub9({4'h0, acc[3:0]}, {4'h0, subtrahend[3:0]});
   wire logic [7:0] inc = mem + 8'h01;
   wire logic inc_nil = (inc == 8'h00);

   assign result = is_sub ? diff[7:0] : inc;
   assign flags[FLAG_BORROW] = ~diff[8];
   assign flags[FLAG_HALF] = ~nib_diff[4];
   assign flags[FLAG_NIL] = (diff[7:0] == 8'h00);
   assign flags[FLAG_WRAP] = (acc[7] ^ subtrahend[7]) & (diff[7] ^ acc[7]);
   assign skip = (is_inc && inc_nil) || ((op == OP_BIT_SET_SKIP) && mem[bit_sel]);
   assign wr_acc = (op == OP_INC_TO_ACC_SKIP) || (op == OP_MINUS_MEM) || is_imm;
   assign wr_mem = (op == OP_INC_SKIP_NIL) || (op == OP_MINUS_TO_MEM);
   assign wr_flags = is_sub;
   assign bad_op = !is_sub && !is_inc && (op != OP_BIT_SET_SKIP);

endmodule
`default_nettype wire

// >>> hw/skip_and_subtract_exec.sv
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module skip_and_subtract_exec
   import skip_sub_pkg::*;
#(
   parameter int DEPTH = RAM_DEPTH_DEF,
   parameter int CYC_DIV = CYC_DIV_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic busy,
   output logic dummy_slot
);

   if (DEPTH < 2 || DEPTH > RAM_WIN_WORDS || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two from 2 to 64.");
   end
   if (CYC_DIV < 2) begin : g_bad_div
      $error("CYC_DIV must be at least 2.");
   end

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(CYC_DIV);

   // Instruction cycle enable.
   logic [CW-1:0] div_q;
   logic ce_q;
   wire logic div_wrap = (div_q == CW'(CYC_DIV - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= '0;
         ce_q <= 1'b0;
      end else begin
         div_q <= div_wrap ? '0 : CW'(div_q + 1'b1);
         ce_q <= div_wrap;
      end
   end

   // Bus side state.
   logic dp_q;
   logic dp_write_q;
   logic dp_word_q;
   logic rd_wait_q;
   logic [11:0] dp_addr_q;
   logic hreadyout_q;
   logic hresp_q;
   logic [31:0] hrdata_q;

   // Execution state.
   exec_state_e st_q;
   exec_state_e st_d;
   op_e op_q;
   logic [2:0] bit_q;
   logic [7:0] addr_q;
   logic [7:0] imm_q;
   logic [7:0] acc_q;
   logic [3:0] flags_q;
   logic skipped_q;
   logic bad_op_q;
   logic [1:0] cycles_q;
   logic busy_q;
   logic dummy_q;

   // Arithmetic results.
   logic [7:0] alu_res;
   logic [3:0] alu_flags;
   logic alu_skip;
   logic alu_wr_acc;
   logic alu_wr_mem;
   logic alu_wr_flags;
   logic alu_bad_op;
   logic [7:0] ram_rdata;

   wire logic busy_w = (st_q != ST_IDLE);
   wire logic exec_fire = (st_q == ST_EXEC);
   wire logic accept = hsel && htrans[1] && hready;

   // The bus waits while an instruction runs, so it never fights execution for the RAM port.
   wire logic bus_step = dp_q && !rd_wait_q && !busy_w;
   wire logic bus_wr = bus_step && dp_write_q && dp_word_q;

   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   wire logic sel_cmd = reg_hit(dp_addr_q, OFS_CMD);
   wire logic sel_acc = reg_hit(dp_addr_q, OFS_ACC);
   wire logic sel_flags = reg_hit(dp_addr_q, OFS_FLAGS);
   wire logic sel_status = reg_hit(dp_addr_q, OFS_STATUS);
   wire logic [5:0] win_idx = dp_addr_q[7:2];
   wire logic sel_ram = (dp_addr_q[11:8] == RAM_WIN_HI) && (32'(win_idx) < DEPTH);
   wire logic [AW-1:0] bus_idx = dp_addr_q[AW+1:2];
   wire logic start_w = bus_wr && sel_cmd;

   wire logic [31:0] cmd_word = {8'h00, imm_q, addr_q, 1'b0, bit_q, 1'b0, op_q};
   wire logic [31:0] status_word = {26'h000_0000, cycles_q, 1'b0, bad_op_q, skipped_q, busy_w};
   wire logic [31:0] rd_word =
      sel_cmd ? cmd_word :
      sel_acc ? {24'h00_0000, acc_q} :
      sel_flags ? {28'h000_0000, flags_q} :
      sel_status ? status_word :
      sel_ram ? {24'h00_0000, ram_rdata} :
      32'h0000_0000;

   // Data memory shares one port between the bus and the running instruction.
   wire logic [AW-1:0] ram_addr = busy_w ? addr_q[AW-1:0] : bus_idx;
   wire logic ram_we = exec_fire ? alu_wr_mem : (bus_wr && sel_ram);
   wire logic [7:0] ram_wdata = exec_fire ? alu_res : hwdata[7:0];

   exec_byte_ram #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_ram (
      .clk(hclk),
      .addr(ram_addr),
      .we(ram_we),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   skip_sub_alu u_alu (
      .op(op_q),
      .acc(acc_q),
      .mem(ram_rdata),
      .imm(imm_q),
      .bit_sel(bit_q),
      .result(alu_res),
      .flags(alu_flags),
      .skip(alu_skip),
      .wr_acc(alu_wr_acc),
      .wr_mem(alu_wr_mem),
      .wr_flags(alu_wr_flags),
      .bad_op(alu_bad_op)
   );

   // Address phase capture and data phase completion.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_word_q <= 1'b0;
         dp_addr_q <= 12'h000;
      end else if (accept) begin
         dp_q <= 1'b1;
         dp_write_q <= hwrite;
         dp_word_q <= (hsize == HSIZE_WORD);
         dp_addr_q <= haddr[11:0];
      end else if ((bus_step && dp_write_q) || rd_wait_q) begin
         dp_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_q <= 1'b0;
      end else begin
         rd_wait_q <= bus_step && !dp_write_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
      end else if (accept) begin
         hreadyout_q <= 1'b0;
      end else if ((bus_step && dp_write_q) || rd_wait_q) begin
         hreadyout_q <= 1'b1;
      end
   end

   // Errors are never signalled, yet the response leaves a flop like every other output.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_q <= 1'b0;
      end else begin
         hresp_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_wait_q) begin
         hrdata_q <= rd_word;
      end
   end

   // Instruction latch; a new command is only taken while idle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_q <= OP_INC_SKIP_NIL;
         bit_q <= 3'h0;
         addr_q <= 8'h00;
         imm_q <= 8'h00;
      end else if (start_w) begin
         op_q <= op_e'(hwdata[CMD_OP_LSB +: 3]);
         bit_q <= hwdata[CMD_BIT_LSB +: 3];
         addr_q <= hwdata[CMD_ADDR_LSB +: 8];
         imm_q <= hwdata[CMD_IMM_LSB +: 8];
      end
   end

   // Sequencer: wait for the cycle boundary, execute, then burn a dummy cycle on a skip.
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (start_w) begin
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (ce_q) begin
               st_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            st_d = alu_skip ? ST_DUMMY : ST_IDLE;
         end
         ST_DUMMY: begin
            if (ce_q) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_IDLE;
         busy_q <= 1'b0;
         dummy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         busy_q <= (st_d != ST_IDLE);
         dummy_q <= (st_d == ST_DUMMY);
      end
   end

   // Accumulator: execution has priority, but the bus cannot write while busy anyway.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= ACC_RST;
      end else if (exec_fire && alu_wr_acc) begin
         acc_q <= alu_res;
      end else if (bus_wr && sel_acc) begin
         acc_q <= hwdata[7:0];
      end
   end

   // Skip instructions leave the flags alone since alu_wr_flags is low for them.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= FLAGS_RST;
      end else if (exec_fire && alu_wr_flags) begin
         flags_q <= alu_flags;
      end else if (bus_wr && sel_flags) begin
         flags_q <= hwdata[3:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         skipped_q <= 1'b0;
         cycles_q <= 2'h0;
      end else if (exec_fire) begin
         skipped_q <= alu_skip;
         cycles_q <= alu_skip ? CYC_TWO : CYC_ONE;
      end
   end

   // Undefined opcodes do nothing but raise a sticky status bit; a new fault beats the clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bad_op_q <= 1'b0;
      end else if (exec_fire && alu_bad_op) begin
         bad_op_q <= 1'b1;
      end else if (bus_wr && sel_status && hwdata[STAT_BAD_OP]) begin
         bad_op_q <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign busy = busy_q;
   assign dummy_slot = dummy_q;

endmodule
`default_nettype wire

// >>> testbench/skip_sub_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module skip_sub_asserts
   import skip_sub_pkg::*;
#(
   parameter int CYC_DIV = CYC_DIV_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic busy,
   input wire logic dummy_slot
);
   localparam int DMAX = CYC_DIV + 1;
   localparam int BMAX = 2 * CYC_DIV + 2;
   localparam int RMAX = 2 * CYC_DIV + 6;
   logic cmd_ph_q;
   logic [2:0] op_q;

   // The opcode is taken at data phase end, so a stalled command never shows up early.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_ph_q <= 1'h0;
         op_q <= 3'h0;
      end else begin
         if (hready) cmd_ph_q <= hsel && htrans[1] && hwrite && (haddr[11:0] == OFS_CMD);
         if (hready && cmd_ph_q) op_q <= hwdata[2:0];
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   dummy_busy_a: assert property (dummy_slot |-> busy)
      else $error("dummy slot outside an instruction");
   dummy_op_a: assert property (dummy_slot |-> (op_q <= 3'h2))
      else $error("dummy slot after a non-skip instruction");
   dummy_after_a: assert property ($rose(dummy_slot) |-> $past(busy))
      else $error("dummy slot without execution before it");
   dummy_len_a: assert property ($rose(dummy_slot) |-> ##[1:DMAX] !dummy_slot)
      else $error("dummy slot longer than one instruction cycle");
   dummy_end_a: assert property ($fell(dummy_slot) |-> !busy)
      else $error("instruction runs on after its dummy slot");
   busy_len_a: assert property ($rose(busy) |-> ##[1:BMAX] !busy)
      else $error("instruction longer than two cycles");
   busy_cause_a: assert property ($rose(busy) |-> (cmd_ph_q || $past(cmd_ph_q)))
      else $error("instruction started without a command write");
   bus_wait_a: assert property (!hreadyout |-> ##[1:RMAX] hreadyout)
      else $error("bus wait longer than an instruction");
endmodule

bind skip_and_subtract_exec skip_sub_asserts #(.CYC_DIV(CYC_DIV)) skip_sub_asserts_i (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hwdata(hwdata),
   .hready(hready),
   .hreadyout(hreadyout),
   .busy(busy),
   .dummy_slot(dummy_slot)
);
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import skip_sub_pkg::*;
   localparam int CD = 2;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, saw_dummy = 1'h0;
   logic hready, hresp, busy, dummy_slot, hreadyout;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r, q;
   logic [31:0] seed = 32'h0000_0031;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = HSIZE_WORD;
   int miscompares = 0, samples_checked = 0;

   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   always @(posedge hclk) if (dummy_slot === 1'h1) saw_dummy <= 1'h1;

   skip_and_subtract_exec #(.CYC_DIV(CD)) skip_and_subtract_exec_i (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .busy(busy),
      .dummy_slot(dummy_slot)
   );

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Returns wrap, nil, half, borrow flags above the difference.
   function automatic logic [11:0] sub_f(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      return {(a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b, d};
   endfunction

   task automatic results();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, s, e);
      end
   endtask

   task automatic wait_ready();
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {20'h0_0000, a};
      hwrite <= 1'h1;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {20'h0_0000, a};
      hwrite <= 1'h0;
      wait_ready();
      htrans <= 2'h0;
      wait_ready();
      check(hrdata, e);
   endtask

   task automatic run(input logic [2:0] op, input logic [2:0] a, input logic [2:0] bt, input logic [7:0] imm,
                      input logic [7:0] acc, input logic [7:0] m, input logic [3:0] fl);
      logic [11:0] s, ma;
      logic [7:0] eacc, emem;
      logic [3:0] efl;
      logic sk;
      eacc = acc;
      emem = m;
      efl = fl;
      sk = 1'h0;
      ma = 12'h100 + {7'h00, a, 2'h0};
      s = sub_f(acc, (op == 3'h5) ? imm : m);
      case (op)
         3'h0: begin emem = m + 8'h01; sk = (emem == 8'h00); end
         3'h1: begin eacc = m + 8'h01; sk = (eacc == 8'h00); end
         3'h2: sk = m[bt];
         3'h3, 3'h5: {efl, eacc} = s;
         3'h4: {efl, emem} = s;
         default: ;
      endcase
      wr(ma, {24'h00_0000, m});
      wr(OFS_ACC, {24'h00_0000, acc});
      wr(OFS_FLAGS, {28'h000_0000, fl});
      saw_dummy <= 1'h0;
      wr(OFS_CMD, {8'h00, imm, 5'h00, a, 1'h0, bt, 1'h0, op});
      rd_chk(OFS_STATUS, {26'h000_0000, sk ? CYC_TWO : CYC_ONE, 1'h0, op > 3'h5, sk, 1'h0});
      check({30'h0000_0000, hresp, saw_dummy}, {30'h0000_0000, 1'h0, sk});
      rd_chk(OFS_CMD, {8'h00, imm, 5'h00, a, 1'h0, bt, 1'h0, op});
      rd_chk(OFS_ACC, {24'h00_0000, eacc});
      rd_chk(OFS_FLAGS, {28'h000_0000, efl});
      rd_chk(ma, {24'h00_0000, emem});
      if (op > 3'h5) begin
         wr(OFS_STATUS, 32'h0000_0004);
         rd_chk(OFS_STATUS, {26'h000_0000, CYC_ONE, 4'h0});
      end
   endtask

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      rd_chk(OFS_ACC, 32'h0000_0000);
      rd_chk(OFS_FLAGS, 32'h0000_0000);
      rd_chk(OFS_STATUS, 32'h0000_0000);
      rd_chk(12'h020, 32'h0000_0000);
      // A byte-sized write must be completed on the bus but leave the accumulator alone.
      hsize <= 3'h0;
      wr(OFS_ACC, 32'h0000_00aa);
      hsize <= HSIZE_WORD;
      rd_chk(OFS_ACC, 32'h0000_0000);
      // Boundary values first: wrap to zero, bit 7 and 0, signed overflow, equal operands.
      run(3'h0, 3'h1, 3'h0, 8'h00, 8'h12, 8'hff, 4'h5);
      run(3'h0, 3'h2, 3'h0, 8'h00, 8'h12, 8'h7f, 4'ha);
      run(3'h1, 3'h3, 3'h0, 8'h00, 8'h34, 8'hff, 4'hf);
      run(3'h1, 3'h3, 3'h0, 8'h00, 8'h34, 8'h00, 4'h0);
      run(3'h2, 3'h4, 3'h7, 8'h00, 8'h00, 8'h80, 4'h9);
      run(3'h2, 3'h4, 3'h6, 8'h00, 8'h00, 8'h80, 4'h6);
      run(3'h2, 3'h5, 3'h0, 8'h00, 8'h00, 8'h01, 4'h3);
      run(3'h3, 3'h6, 3'h0, 8'h00, 8'h00, 8'h01, 4'hf);
      run(3'h3, 3'h6, 3'h0, 8'h00, 8'h80, 8'h01, 4'h0);
      run(3'h4, 3'h7, 3'h0, 8'h00, 8'h10, 8'h10, 4'h0);
      run(3'h4, 3'h0, 3'h0, 8'h00, 8'h7f, 8'hff, 4'h0);
      run(3'h5, 3'h0, 3'h0, 8'hff, 8'h7f, 8'h55, 4'h0);
      run(3'h5, 3'h0, 3'h0, 8'h08, 8'h10, 8'h55, 4'hf);
      run(3'h6, 3'h1, 3'h0, 8'h01, 8'h22, 8'h33, 4'hc);
      run(3'h7, 3'h1, 3'h0, 8'h01, 8'h22, 8'h33, 4'h3);
      repeat (60) begin
         r = rnd();
         q = rnd();
         run(r[2:0], r[5:3], r[8:6], r[15:8], r[23:16], r[31:24], q[3:0]);
      end
      results();
   end

   // Each instruction costs under two hundred cycles of bus traffic; this is many times that.
   initial begin
      #400_000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
